// ### pmd_pkg.sv
/*
  Package for the master transfer engine: register offsets, field
  positions, reset values, result codes and the carrier structs.
  Assumes a single PCI clock domain.
*/
package pmd_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_ADDR = 8'h54;
  localparam logic [7:0] OFS_CNT = 8'h58;
  localparam logic [7:0] OFS_CTL = 8'h5c;

  // ==========================================================
  // Control field positions
  localparam int CTL_RES_LO = 0;
  localparam int CTL_DONE = 2;
  localparam int CTL_START = 3;
  localparam int CTL_CMD_LO = 4;
  localparam int CTL_EN = 8;
  localparam int CTL_W64 = 9;
  localparam int CTL_FLUSH = 10;
  localparam int CTL_IRQ_ST = 12;
  localparam int CTL_IRQ_EN = 13;
  localparam int CTL_BE_LO = 16;
  localparam int CTL_HI_LO = 26;

  // ==========================================================
  // Result codes and constants
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_MABORT = 2'h1;
  localparam logic [1:0] RES_PARITY = 2'h2;
  localparam logic [1:0] RES_TABORT = 2'h3;
  localparam logic [2:0] WIN_DIRECT = 3'h7;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [3:0] RST_CMD = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h0;
  localparam logic [5:0] RST_HI = 6'h0;
  localparam logic [3:0] STEP32 = 4'h4;
  localparam logic [3:0] STEP64 = 4'h8;

  // ==========================================================
  // Carrier structs and sequencer state encoding
  typedef struct packed {
    logic [3:0] cmd;
    logic w64;
    logic to_backend;
    logic direct;
    logic [2:0] window;
    logic [7:0] byte_en_n;
  } pmd_xfer_s;

  typedef struct packed {
    logic ack;
    logic mabort;
    logic tabort;
    logic perr;
  } pmd_resp_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } pmd_state_e;

endpackage

// ### pmd_engine.sv
/*
  Master transfer engine: address/data, count and control registers,
  and the sequencer that steps data phases between PCI and backend.
  Assumes the PCI master controller and backend memory run on clk and
  answer each data phase with a one-cycle response pulse.
*/
// How it works
// [RL1] Address bits 1:0 read zero
// [RL2] Address width set by parameter, advances
// [RL3] Software aligns address for 64-bit transfers
// [RL4] Direct option: register holds data word
// [RL5] Direct variant ignores address bits 1:0
// [RL6] Count in bytes, low bits read zero
// [RL7] Zero count moves two-power bytes
// [RL8] Two-bit result code reports outcome
// [RL9] Done bit sets, software zero clears
// [RL10] Start bit runs until end, self-clears
// [RL11] Start refused without bus-master enable
// [RL12] Cycle type drives PCI command, direction
// [RL13] Read codes move PCI to backend
// [RL14] Write codes move backend to PCI
// [RL15] Engine enable required for any transfer
// [RL16] Width bit selects 64-bit, else zero
// [RL17] Flush bit empties FIFOs, reads zero
// [RL18] Direct mode: one word, no backend
// [RL19] Completion sets status, write-one clears
// [RL20] Software waits for start clear
// [RL21] Each phase advances address, reduces count
// [RL22] Abort records code, clears start together
module pmd_engine
  import pmd_pkg::*;
#(
  parameter int backend_addr_bits = 20,
  parameter int count_bits_param = 16,
  parameter bit direct_transfer_option = 1'b0,
  parameter bit core_64bit = 1'b1,
  parameter bit fifo_recovery = 1'b1
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic bus_master_en,
  output logic xfer_req,
  output pmd_xfer_s xfer_ctl,
  input wire pmd_resp_s pci_resp,
  input wire logic [63:0] pci_rdata,
  output logic [63:0] pci_wdata,
  output logic [31:0] be_addr,
  output logic be_we,
  output logic be_re,
  output logic [63:0] be_wdata,
  input wire logic [63:0] be_rdata,
  output logic fifo_flush,
  output logic done_irq
);

  localparam int AW = backend_addr_bits;
  localparam int CW = count_bits_param;

  pmd_state_e state_ff;
  logic [31:0] addr_ff;
  logic [CW:0] cnt_ff;
  logic [1:0] res_ff;
  logic done_ff;
  logic start_ff;
  logic [3:0] cmd_ff;
  logic en_ff;
  logic w64_ff;
  logic irq_st_ff;
  logic irq_en_ff;
  logic [7:0] be_n_ff;
  logic [5:0] hi_ff;
  logic flush_ff;
  logic [31:0] rd_ff;

  logic wr_addr, wr_cnt, wr_ctl;
  logic direct;
  logic phase;
  logic last;
  logic abort;
  logic [3:0] step;
  logic [CW:0] step_w;
  logic [31:0] nxt_addr;
  logic [31:0] addr_mask;
  logic [31:0] cnt_view;
  logic [31:0] ctl_view;

  // ==========================================================
  // Decode
  always_comb
  begin
    wr_addr = 1'b0;
    wr_cnt = 1'b0;
    wr_ctl = 1'b0;
    if (reg_wr && reg_addr == OFS_ADDR)
    begin
      wr_addr = 1'b1;
    end
    else if (reg_wr && reg_addr == OFS_CNT)
    begin
      wr_cnt = 1'b1;
    end
    else if (reg_wr && reg_addr == OFS_CTL)
    begin
      wr_ctl = 1'b1;
    end
  end

  // [RL18] Direct window select
  assign direct = direct_transfer_option && hi_ff[2:0] == WIN_DIRECT;
  // [RL16] Width step
  assign step = w64_ff ? STEP64 : STEP32;
  assign step_w = (CW + 1)'(step);
  assign phase = state_ff == ST_BUSY && pci_resp.ack;
  assign last = cnt_ff <= step_w;
  // [RL22] Abort ends transfer
  assign abort = state_ff == ST_BUSY
    && (pci_resp.mabort || pci_resp.tabort);

  // [RL2] Implemented address bits
  always_comb
  begin
    addr_mask = RST_WORD;
    addr_mask[AW-1:2] = '1;
  end

  // ==========================================================
  // Address or direct data register
  // [RL21] Address advance per phase
  assign nxt_addr = addr_ff + {28'h0, step};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_ff <= RST_WORD;
    end
    else if (phase && direct && xfer_ctl.to_backend)
    begin
      // [RL4] Capture direct data word
      addr_ff <= pci_rdata[31:0];
    end
    else if (phase && !direct)
    begin
      addr_ff <= nxt_addr & addr_mask;
    end
    else if (wr_addr)
    begin
      // [RL4] Full word in direct variant
      addr_ff <= direct_transfer_option ? reg_wdata
        : reg_wdata & addr_mask;
    end
  end

  // ==========================================================
  // Count register, one extra bit holds the zero-count span
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
    end
    else if (phase)
    begin
      // [RL21] Count down per phase
      cnt_ff <= last ? '0 : cnt_ff - step_w;
    end
    else if (state_ff == ST_IDLE && start_ff && en_ff
             && cnt_ff[CW-1:0] == '0)
    begin
      // [RL7] Zero count expands
      cnt_ff <= {1'b1, {CW{1'b0}}};
    end
    else if (wr_cnt)
    begin
      // [RL6] Low bits forced zero
      cnt_ff <= {1'b0, reg_wdata[CW-1:2], 2'b00};
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          // [RL15] Enable gates transfer
          if (start_ff && en_ff)
          begin
            state_ff <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (abort || (phase && last))
          begin
            state_ff <= ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Start bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_ff <= 1'b0;
    end
    // [RL10] Self-clear at end
    else if (abort || (phase && last))
    begin
      start_ff <= 1'b0;
    end
    // [RL11] Needs bus-master enable
    else if (wr_ctl && reg_wdata[CTL_START] && bus_master_en)
    begin
      start_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Result, done and completion status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      res_ff <= RES_OK;
    end
    // [RL8] Record outcome code
    else if (state_ff == ST_BUSY && pci_resp.mabort)
    begin
      res_ff <= RES_MABORT;
    end
    else if (state_ff == ST_BUSY && pci_resp.tabort)
    begin
      res_ff <= RES_TABORT;
    end
    else if (state_ff == ST_BUSY && pci_resp.perr)
    begin
      res_ff <= RES_PARITY;
    end
    else if (wr_ctl)
    begin
      res_ff <= reg_wdata[CTL_RES_LO+1:CTL_RES_LO];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_ff <= 1'b0;
      irq_st_ff <= 1'b0;
    end
    else
    begin
      // [RL9] Set wins over clear
      if (phase && last)
      begin
        done_ff <= 1'b1;
      end
      else if (wr_ctl && !reg_wdata[CTL_DONE])
      begin
        done_ff <= 1'b0;
      end
      // [RL19] Status set, write-one clear
      if (phase && last)
      begin
        irq_st_ff <= 1'b1;
      end
      else if (wr_ctl && reg_wdata[CTL_IRQ_ST])
      begin
        irq_st_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Plain control fields
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_ff <= RST_CMD;
      en_ff <= 1'b0;
      w64_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      be_n_ff <= RST_BYTE;
      hi_ff <= RST_HI;
    end
    else if (wr_ctl)
    begin
      // [RL12] Command code stored raw
      cmd_ff <= reg_wdata[CTL_CMD_LO+3:CTL_CMD_LO];
      en_ff <= reg_wdata[CTL_EN];
      // [RL16] Zero in 32-bit cores
      w64_ff <= core_64bit && reg_wdata[CTL_W64];
      irq_en_ff <= reg_wdata[CTL_IRQ_EN];
      be_n_ff <= reg_wdata[CTL_BE_LO+7:CTL_BE_LO];
      hi_ff <= reg_wdata[CTL_HI_LO+5:CTL_HI_LO];
    end
  end

  // [RL17] Flush pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flush_ff <= 1'b0;
    end
    else
    begin
      flush_ff <= fifo_recovery && wr_ctl && reg_wdata[CTL_FLUSH];
    end
  end

  // ==========================================================
  // Read-back
  always_comb
  begin
    cnt_view = RST_WORD;
    cnt_view[CW-1:2] = cnt_ff[CW-1:2];
    ctl_view = RST_WORD;
    ctl_view[CTL_RES_LO+1:CTL_RES_LO] = res_ff;
    ctl_view[CTL_DONE] = done_ff;
    ctl_view[CTL_START] = start_ff;
    ctl_view[CTL_CMD_LO+3:CTL_CMD_LO] = cmd_ff;
    ctl_view[CTL_EN] = en_ff;
    ctl_view[CTL_W64] = w64_ff;
    ctl_view[CTL_IRQ_ST] = irq_st_ff;
    ctl_view[CTL_IRQ_EN] = irq_en_ff;
    ctl_view[CTL_BE_LO+7:CTL_BE_LO] = core_64bit ? be_n_ff
      : {4'h0, be_n_ff[3:0]};
    ctl_view[CTL_HI_LO+5:CTL_HI_LO] = hi_ff;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ff <= RST_WORD;
    end
    else if (reg_rd && reg_addr == OFS_ADDR)
    begin
      // [RL1] Low bits zero unless the direct option is built in
      rd_ff <= direct_transfer_option ? addr_ff
        : addr_ff & addr_mask;
    end
    else if (reg_rd && reg_addr == OFS_CNT)
    begin
      rd_ff <= cnt_view;
    end
    else if (reg_rd && reg_addr == OFS_CTL)
    begin
      rd_ff <= ctl_view;
    end
    else if (reg_rd)
    begin
      rd_ff <= RST_WORD;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = rd_ff;
  assign xfer_req = state_ff == ST_BUSY;
  assign xfer_ctl.cmd = cmd_ff;
  assign xfer_ctl.w64 = w64_ff;
  // [RL13] Even codes read into backend
  // [RL14] Odd codes write to PCI
  assign xfer_ctl.to_backend = !cmd_ff[0];
  assign xfer_ctl.direct = direct;
  assign xfer_ctl.window = hi_ff[2:0];
  assign xfer_ctl.byte_en_n = be_n_ff;
  // [RL5] Word-aligned backend address
  assign be_addr = addr_ff & addr_mask;
  // [RL18] No backend cycle when direct
  assign be_we = phase && xfer_ctl.to_backend && !direct;
  assign be_re = xfer_req && !xfer_ctl.to_backend && !direct;
  assign be_wdata = pci_rdata;
  assign pci_wdata = direct ? {32'h0, addr_ff} : be_rdata;
  assign fifo_flush = flush_ff;
  assign done_irq = irq_st_ff && irq_en_ff;

endmodule

// ### pmd_monitor.sv
/*
  Port checker for pmd_engine.
  Assumes it is bound into pmd_engine.
*/
module pmd_monitor
  import pmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic bus_master_en,
  input wire logic xfer_req,
  input wire pmd_xfer_s xfer_ctl,
  input wire pmd_resp_s pci_resp,
  input wire logic be_we,
  input wire logic be_re,
  input wire logic fifo_flush
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_no_bme;
    reg_wr && reg_addr == OFS_CTL && reg_wdata[CTL_START]
      && !bus_master_en && !xfer_req |=> !xfer_req [*3];
  endproperty
  a_no_bme: assert property (p_no_bme) else $error("start taken");

  property p_no_en;
    reg_wr && reg_addr == OFS_CTL && !reg_wdata[CTL_EN] && !xfer_req
      |=> !xfer_req [*3];
  endproperty
  a_no_en: assert property (p_no_en) else $error("ran disabled");

  property p_busy;
    xfer_req && !pci_resp.ack && !pci_resp.mabort && !pci_resp.tabort
      |=> xfer_req;
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped");

  property p_abort;
    xfer_req && (pci_resp.mabort || pci_resp.tabort) |=> !xfer_req;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_dir;
    xfer_req && !xfer_ctl.direct |-> be_re == xfer_ctl.cmd[0];
  endproperty
  a_dir: assert property (p_dir) else $error("bad direction");

  property p_bwr;
    xfer_req && pci_resp.ack && !xfer_ctl.cmd[0] && !xfer_ctl.direct
      |-> be_we;
  endproperty
  a_bwr: assert property (p_bwr) else $error("no backend write");

  property p_flush;
    reg_wr && reg_addr == OFS_CTL && reg_wdata[CTL_FLUSH]
      |=> fifo_flush ##1 !fifo_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse");

  property p_alow;
    reg_rd && reg_addr == OFS_ADDR
      |=> reg_rdata[1:0] == 2'h0 && reg_rdata[31:20] == 12'h0;
  endproperty
  a_alow: assert property (p_alow) else $error("addr bits");
endmodule

// ### pmd_partner.sv
/*
  PCI target and backend memory model for pmd_engine.
  Assumes registered one-cycle responses on clk.
*/
module pmd_partner
  import pmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic xfer_req,
  input wire logic [31:0] be_addr,
  input wire logic [63:0] pci_wdata,
  input wire logic [3:0] lat,
  input wire logic [1:0] fault,
  output pmd_resp_s pci_resp,
  output logic [63:0] pci_rdata,
  output logic [63:0] be_rdata,
  output int acks,
  output logic [63:0] last_wd
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Responder
  logic [3:0] wait_ff;
  logic first_ff;
  logic [31:0] cyc_ff;
  assign be_rdata = {~be_addr, be_addr};
  // Changes every cycle, data phases included
  assign pci_rdata = {~cyc_ff, cyc_ff};
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cyc_ff <= 32'h0;
      wait_ff <= 4'h0;
      first_ff <= 1'b1;
      pci_resp <= '0;
      acks <= 0;
      last_wd <= 64'h0;
    end
    else
    begin
      cyc_ff <= cyc_ff + 32'h1;
      pci_resp <= '0;
      if (!xfer_req)
      begin
        wait_ff <= lat;
        first_ff <= 1'b1;
      end
      else if (pci_resp != '0)
        wait_ff <= lat;
      else if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      else
      begin
        first_ff <= 1'b0;
        if (first_ff && fault == 2'h1)
          pci_resp.mabort <= 1'b1;
        else if (first_ff && fault == 2'h2)
          pci_resp.tabort <= 1'b1;
        else
        begin
          pci_resp.ack <= 1'b1;
          pci_resp.perr <= first_ff && fault == 2'h3;
          acks <= acks + 1;
          last_wd <= pci_wdata;
        end
      end
    end
endmodule

// ### pmd_engine_tb.sv
/*
  Self-checking bench for pmd_engine with an integer model.
  Assumes pmd_partner and pmd_monitor are compiled first.
*/
module pmd_engine_tb
  import pmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, bus_master_en = 0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, be_addr;
  logic xfer_req, be_we, be_re, fifo_flush, done_irq;
  pmd_xfer_s xfer_ctl;
  pmd_resp_s pci_resp;
  logic [63:0] pci_rdata, pci_wdata, be_wdata, be_rdata, last_wd;
  logic [3:0] lat = 4'h0;
  logic [1:0] fault = 2'h0;
  int fail_count = 0, comparisons = 0, cycles = 0, acks;
  integer seed = 32'hb60d;
  int bw_n = 0;
  logic [63:0] bw_got, bw_exp;
  int faults[$] = '{1, 2, 3};
  always #25 clk = ~clk;

  pmd_engine #(.count_bits_param(8)) dut (.clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .bus_master_en, .xfer_req,
    .xfer_ctl, .pci_resp, .pci_rdata, .pci_wdata, .be_addr, .be_we,
    .be_re, .be_wdata, .be_rdata, .fifo_flush, .done_irq);
  pmd_partner far (.clk, .rst, .xfer_req, .be_addr, .pci_wdata, .lat,
    .fault, .pci_resp, .pci_rdata, .be_rdata, .acks, .last_wd);

  // Backend writes seen mid-cycle, with the PCI data of each phase
  always @(negedge clk)
  begin
    if (be_we)
    begin
      bw_n <= bw_n + 1;
      bw_got <= be_wdata;
    end
    if (pci_resp.ack)
    begin
      bw_exp <= pci_rdata;
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rchk(string w, logic [7:0] a, logic [31:0] e);
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 0;
    chk(w, e, reg_rdata);
  endtask
  task automatic run(int c, int w, int n, int f);
    logic [31:0] a, r, e;
    int st, k, kb, ab, rd;
    st = w ? 8 : 4;
    ab = f == 1 || f == 2;
    rd = c % 2 == 0 && !ab;
    k = acks;
    kb = bw_n;
    a = 32'($random(seed)) & 32'h000ffff8;
    lat = 4'($random(seed) & 3);
    fault = 2'(f);
    r = f == 1 ? 32'h1 : f == 2 ? 32'h3 : f == 3 ? 32'h2 : 32'h0;
    wr(OFS_ADDR, a);
    wr(OFS_CNT, 32'(n * st));
    wr(OFS_CTL, 32'(c << 4) | 32'(w << 9) | 32'h2108);
    repeat (3) @(negedge clk);
    // A hang is caught by the cycle ceiling
    while (xfer_req) @(negedge clk);
    chk("irq", 32'(!ab), 32'(done_irq));
    chk("acks", 32'(ab ? 0 : n), 32'(acks - k));
    chk("bwr", 32'(rd ? n : 0), 32'(bw_n - kb));
    if (rd)
    begin
      chk("bdata_lo", bw_exp[31:0], bw_got[31:0]);
      chk("bdata_hi", bw_exp[63:32], bw_got[63:32]);
    end
    e = (a + 32'((n - 1) * st)) & 32'hffffc;
    if (c % 2 == 1 && !ab)
      chk("wdata", e, last_wd[31:0]);
    e = r | 32'(c << 4) | 32'(w << 9) | 32'h2100 | (ab ? 32'h0 : 32'h1004);
    rchk("ctl", OFS_CTL, e);
    e = (a + 32'(ab ? 0 : n * st)) & 32'hffffc;
    rchk("addr", OFS_ADDR, e);
    rchk("cnt", OFS_CNT, ab ? 32'(n * st) & 32'hfc : 32'h0);
    wr(OFS_CTL, 32'h1000);
    rchk("clear", OFS_CTL, 32'h0);
  endtask
  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 0;
    wr(OFS_ADDR, 32'hffffffff);
    rchk("addr_ro", OFS_ADDR, 32'h000ffffc);
    wr(OFS_CNT, 32'hffffffff);
    rchk("cnt_ro", OFS_CNT, 32'h000000fc);
    rchk("unmapped", 8'h60, 32'h0);
    wr(OFS_CTL, 32'h00000c00);
    rchk("flush_ro", OFS_CTL, 32'h0);
    wr(OFS_CTL, 32'h0108);
    rchk("no_start", OFS_CTL, 32'h0100);
    bus_master_en = 1;
    wr(OFS_CTL, 32'h0008);
    repeat (3) @(negedge clk);
    chk("idle", 32'h0, 32'(xfer_req));
    for (int c = 0; c < 16; c++)
      run(c, $random(seed) & 1, 1 + ($random(seed) & 3), 0);
    run(6, 0, 64, 0);
    foreach (faults[i]) run(faults[i] == 2 ? 7 : 6, 0, 2, faults[i]);
    finish_test();
  end
endmodule

bind pmd_engine pmd_monitor mon (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .bus_master_en, .xfer_req, .xfer_ctl,
  .pci_resp, .be_we, .be_re, .fifo_flush);
